// [verilog/link_regs_pkg.sv]
// Constants and types for the link control and interrupt register bank
package link_regs_pkg;

   // Register byte offsets
   localparam logic [7:0] link_control_offset      = 8'h08;
   localparam logic [7:0] interrupt_flags_offset   = 8'h0C;
   localparam logic [7:0] interrupt_enables_offset = 8'h10;
   localparam logic [7:0] iso_channels_offset      = 8'h14;
   localparam logic [7:0] diagnostics_offset       = 8'h20;

   // Control field positions
   localparam int cycle_master_enable_bit = 20;
   localparam int cycle_source_select_bit = 21;
   localparam int cycle_timer_run_bit     = 22;
   localparam int cycle_mark_insert_bit   = 23;
   localparam int iso_port_one_accept_bit = 24;
   localparam int iso_port_two_accept_bit = 25;
   localparam int extended_pins_drive_bit = 31;
   localparam logic [31:0] link_control_writable = 32'hC3F0_0000 & 32'h83F0_0000;

   // Channel fields and diagnostics
   localparam int iso_channel_one_lsb      = 0;
   localparam int iso_channel_two_lsb      = 8;
   localparam int channel_width            = 6;
   localparam int interrupt_write_mode_bit = 0;

   // Interrupt layout
   localparam int interrupt_summary_bit   = 0;
   localparam int summary_mask_enable_bit = 0;

   // Reset values
   localparam logic [31:0] link_control_reset      = 32'h0000_0000;
   localparam logic [31:0] interrupt_flags_reset   = 32'h0100_0000;
   localparam logic [31:0] interrupt_enables_reset = 32'h0000_0000;
   localparam logic [31:0] iso_channels_reset      = 32'h0000_0000;
   localparam logic [31:0] diagnostics_reset       = 32'h0000_0000;

   // Cycle timer counts
   localparam int ticks_per_cycle  = 3072;
   localparam int cycles_per_frame = 8000;

   // Received isochronous packet header
   typedef struct packed {
      logic       valid;
      logic [5:0] channel;
   } iso_header_type;

   // One three-state pin: drive level and enable
   typedef struct packed {
      logic drive;
      logic enable;
   } pin_drive_type;

endpackage

// [verilog/link_control_and_interrupt_regs.sv]
// Link control fields, cycle timer and interrupt flag/mask logic with an APB slave
// Functional notes
// - cycle master sends cycle start on count increment
// - bus reset never clears cycle master enable
// - external source: edge increments count, clears ticks
// - internal source: tick wrap increments cycle count
// - ticks advance only while timer run set
// - cycle marks written at cycle end when enabled
// - port one accepts matching channel one packets
// - port two accepts matching channel two packets
// - extended pins driven only when enabled, resets off
// - flags at 0x0C, mask at 0x10
// - mask register read/write, resets to zero
// - write-one clears flags, summary unaffected
// - write mode one makes all flags read/write
// - flag register resets to documented value
// - events set flags; masked flags set summary
// - interrupt pin is summary and summary enable
// - summary recomputed continuously from set flags
// - summary sits at flag bit zero
module link_control_and_interrupt_regs
#(
   parameter int ticks_per_cycle  = link_regs_pkg::ticks_per_cycle,
   parameter int cycles_per_frame = link_regs_pkg::cycles_per_frame
)
(
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [7:0]                    paddr,
   input  wire logic [31:0]                   pwdata,
   output logic [31:0]                        prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic                          root_attached,
   input  wire logic                          external_cycle_input,
   input  wire logic                          iso_cycle_end,
   input  wire logic                          fifo_empty,
   input  wire link_regs_pkg::iso_header_type iso_header,
   input  wire logic [31:1]                   interrupt_events,
   output logic                               cycle_start_send,
   output logic                               cycle_mark_write,
   output logic                               iso_port_one_hit,
   output logic                               iso_port_two_hit,
   output logic [12:0]                        cycle_number,
   output logic [11:0]                        subcycle_ticks,
   output link_regs_pkg::pin_drive_type       receive_fifo_empty_pin,
   output link_regs_pkg::pin_drive_type       cycle_done_pin,
   output link_regs_pkg::pin_drive_type       cycle_start_pin,
   output logic                               interrupt_request_pin
);

   logic [31:0] link_control;
   logic [31:0] interrupt_enables;
   logic [31:0] iso_channels;
   logic [31:0] diagnostics;
   logic [31:1] flag_bits;
   logic        summary_written;
   logic        interrupt_summary;
   logic [31:0] interrupt_flags;
   logic        setup_phase;
   logic        write_access;
   logic        address_known;
   logic [31:0] next_prdata;
   logic        cycle_sync_first;
   logic        cycle_sync_second;
   logic        cycle_sync_last;
   logic        cycle_edge;
   logic        tick_wrap;
   logic        count_step;
   logic        interrupt_write_mode;
   logic [5:0]  iso_channel_one_field;
   logic [5:0]  iso_channel_two_field;

   localparam logic [11:0] last_tick  = 12'(ticks_per_cycle - 1);
   localparam logic [12:0] last_cycle = 13'(cycles_per_frame - 1);

   // Bus timing
   // Zero wait states, pready tied high
   // Read data latched in the setup cycle
   // Read data stands until the next setup
   // Write lands at the access-cycle edge
   // Unmapped offset: error answer, no write
   // Unwritable control bits read back as zero
   // Back-to-back transfers need no idle cycle

   // Register map
   // Control word at its own offset
   // Flag word and mask word side by side
   // Channel word: two six-bit channel fields
   // Diagnostics word: write mode in bit zero
   // Every other offset answers with an error

   // Control word
   // Only the documented control bits are kept
   // No hardware path ever clears the word
   // Cycle master role kept across bus resets
   // Software owns the master bit after a reset
   // Pin drive bit off after power-up

   // Flag word
   // Bits 31 to 1 hold latched source events
   // Bit zero is the summary, not a latch
   // Write-one-to-clear while write mode is off
   // Direct write of every bit while it is on
   // An event in the clear cycle stays set
   // Hazard: clearing must never lose an event
   // Summary write only sticks in write mode
   // A written summary holds until rewritten

   // Mask word
   // Plain read/write, cleared at reset
   // Bit n gates flag bit n into the summary
   // Bit zero gates the summary onto the pin
   // Unmasked flags stay visible in the word

   // Summary and request pin
   // Summary recomputed every cycle
   // Clearing it while flags remain has no effect
   // Request pin is combinational from flops
   // No extra delay between flag and pin

   // Cycle timer
   // Ticks advance only while the run bit is set
   // Ticks wrap at the last tick of a cycle
   // Internal source: wrap steps the count
   // External source: synchronised rising edge
   // External edge also zeroes the ticks
   // Zeroing happens even with the timer stopped
   // Cycle count wraps at the last cycle
   // Small counts let a bench reach the wrap

   // External cycle input
   // Two flops before any logic reads it
   // Third flop only for edge detection
   // Step lands three edges after the pin rises
   // All flops reset low, matching the idle pin

   // Cycle start and cycle marks
   // Start request only when master and root
   // Start request is a one-cycle pulse
   // Mark request follows cycle end by one edge
   // No marks while mark insert is off

   // Channel filters
   // Each port compares its own channel field
   // A hit needs the port accept bit
   // Hits are one-cycle pulses, one edge late
   // Both ports may hit on the same header

   // Extended pins
   // Levels come from flops, one edge late
   // Enables follow the pin drive bit directly
   // Enable high means the pin is driven
   // All three enables always agree

   // Field views
   assign interrupt_write_mode  = diagnostics[link_regs_pkg::interrupt_write_mode_bit];
   assign iso_channel_one_field = iso_channels[link_regs_pkg::iso_channel_one_lsb +: 6];
   assign iso_channel_two_field = iso_channels[link_regs_pkg::iso_channel_two_lsb +: 6];

   // APB decode: read data captured in setup, answer in first access cycle
   assign setup_phase  = psel && !penable;
   assign write_access = psel && penable && pwrite && address_known;
   assign pready       = 1'b1;

   // Address decode
   always_comb
   begin
      address_known = 1'b1;
      next_prdata   = 32'h0000_0000;
      unique case (paddr)
         link_regs_pkg::link_control_offset:      next_prdata = link_control;
         link_regs_pkg::interrupt_flags_offset:   next_prdata = interrupt_flags;
         link_regs_pkg::interrupt_enables_offset: next_prdata = interrupt_enables;
         link_regs_pkg::iso_channels_offset:      next_prdata = iso_channels;
         link_regs_pkg::diagnostics_offset:       next_prdata = diagnostics;
         default:                                 address_known = 1'b0;
      endcase
   end

   // Read data and error answer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (setup_phase)
      begin
         prdata  <= next_prdata;
         pslverr <= !address_known;
      end
   end

   // Control register; no bus-reset input touches it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         link_control <= link_regs_pkg::link_control_reset;
      else if (write_access && paddr == link_regs_pkg::link_control_offset)
         link_control <= pwdata & link_regs_pkg::link_control_writable;
   end

   // Channel and diagnostics registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         iso_channels <= link_regs_pkg::iso_channels_reset;
         diagnostics  <= link_regs_pkg::diagnostics_reset;
      end
      else if (write_access)
      begin
         if (paddr == link_regs_pkg::iso_channels_offset)
            iso_channels <= pwdata & 32'h0000_3F3F;
         if (paddr == link_regs_pkg::diagnostics_offset)
            diagnostics <= pwdata & 32'h0000_0001;
      end
   end

   // Mask register, fully read/write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         interrupt_enables <= link_regs_pkg::interrupt_enables_reset;
      else if (write_access && paddr == link_regs_pkg::interrupt_enables_offset)
         interrupt_enables <= pwdata;
   end

   // Flags: events win over a clear or a write in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_bits <= link_regs_pkg::interrupt_flags_reset[31:1];
      else if (write_access && paddr == link_regs_pkg::interrupt_flags_offset)
      begin
         if (interrupt_write_mode)
            flag_bits <= pwdata[31:1] | interrupt_events;
         else
            flag_bits <= (flag_bits & ~pwdata[31:1]) | interrupt_events;
      end
      else
         flag_bits <= flag_bits | interrupt_events;
   end

   // Summary bit held by software only in read/write mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         summary_written <= link_regs_pkg::interrupt_flags_reset[0];
      else if (write_access && paddr == link_regs_pkg::interrupt_flags_offset
               && interrupt_write_mode)
         summary_written <= pwdata[link_regs_pkg::interrupt_summary_bit];
   end

   // Summary: written summary bit OR masked flags, mask bit aligned with flag bit
   assign interrupt_summary = summary_written
                            | (|(flag_bits & interrupt_enables[31:1]));
   assign interrupt_flags   = {flag_bits, interrupt_summary};
   assign interrupt_request_pin = interrupt_summary
      && interrupt_enables[link_regs_pkg::summary_mask_enable_bit];

   // Synchroniser for the external cycle source
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cycle_sync_first  <= 1'b0;
         cycle_sync_second <= 1'b0;
         cycle_sync_last   <= 1'b0;
      end
      else
      begin
         cycle_sync_first  <= external_cycle_input;
         cycle_sync_second <= cycle_sync_first;
         cycle_sync_last   <= cycle_sync_second;
      end
   end

   // Cycle stepping source
   assign cycle_edge = cycle_sync_second && !cycle_sync_last;
   assign tick_wrap  = link_control[link_regs_pkg::cycle_timer_run_bit]
                    && subcycle_ticks == last_tick;
   assign count_step = link_control[link_regs_pkg::cycle_source_select_bit]
                     ? cycle_edge
                     : tick_wrap;

   // Subcycle tick counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         subcycle_ticks <= 12'h000;
      else if (link_control[link_regs_pkg::cycle_source_select_bit] && cycle_edge)
         subcycle_ticks <= 12'h000;
      else if (link_control[link_regs_pkg::cycle_timer_run_bit])
         subcycle_ticks <= tick_wrap ? 12'h000 : subcycle_ticks + 12'h001;
   end

   // Cycle number counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cycle_number <= 13'h0000;
      else if (count_step)
         cycle_number <= (cycle_number == last_cycle) ? 13'h0000
                                                      : cycle_number + 13'h0001;
   end

   // Cycle start and cycle mark requests
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cycle_start_send <= 1'b0;
         cycle_mark_write <= 1'b0;
      end
      else
      begin
         cycle_start_send <= count_step && root_attached
            && link_control[link_regs_pkg::cycle_master_enable_bit];
         cycle_mark_write <= iso_cycle_end
            && link_control[link_regs_pkg::cycle_mark_insert_bit];
      end
   end

   // Isochronous channel filters
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         iso_port_one_hit <= 1'b0;
         iso_port_two_hit <= 1'b0;
      end
      else
      begin
         iso_port_one_hit <= iso_header.valid && iso_header.channel == iso_channel_one_field
            && link_control[link_regs_pkg::iso_port_one_accept_bit];
         iso_port_two_hit <= iso_header.valid && iso_header.channel == iso_channel_two_field
            && link_control[link_regs_pkg::iso_port_two_accept_bit];
      end
   end

   // Extended pins, levels from flops, enables from the control bit
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         receive_fifo_empty_pin.drive <= 1'b0;
         cycle_done_pin.drive         <= 1'b0;
         cycle_start_pin.drive        <= 1'b0;
      end
      else
      begin
         receive_fifo_empty_pin.drive <= fifo_empty;
         cycle_done_pin.drive         <= iso_cycle_end;
         cycle_start_pin.drive        <= count_step;
      end
   end

   assign receive_fifo_empty_pin.enable = link_control[link_regs_pkg::extended_pins_drive_bit];
   assign cycle_done_pin.enable  = link_control[link_regs_pkg::extended_pins_drive_bit];
   assign cycle_start_pin.enable = link_control[link_regs_pkg::extended_pins_drive_bit];

endmodule // link_control_and_interrupt_regs

// [dv/link_regs_props.sv]
// Port assertions for the link control and interrupt bank
module link_regs_props
(
   input wire logic                          pclk,
   input wire logic                          presetn,
   input wire logic                          root_attached,
   input wire logic                          iso_cycle_end,
   input wire logic                          fifo_empty,
   input wire link_regs_pkg::iso_header_type iso_header,
   input wire logic                          cycle_start_send,
   input wire logic                          cycle_mark_write,
   input wire logic                          iso_port_one_hit,
   input wire logic [12:0]                   cycle_number,
   input wire logic [11:0]                   subcycle_ticks,
   input wire link_regs_pkg::pin_drive_type  receive_fifo_empty_pin,
   input wire link_regs_pkg::pin_drive_type  cycle_done_pin,
   input wire link_regs_pkg::pin_drive_type  cycle_start_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking main_cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Pin, timer and pulse relations
   pins_enable_a: assert property (
      receive_fifo_empty_pin.enable == cycle_done_pin.enable
      && cycle_done_pin.enable == cycle_start_pin.enable) else $error("pin enables differ");
   start_root_a: assert property (
      cycle_start_send |-> $past(root_attached)) else $error("start without root");
   start_pin_a: assert property (
      cycle_start_send |-> cycle_start_pin.drive) else $error("start pin missing");
   step_zero_a: assert property (
      $changed(cycle_number) |-> subcycle_ticks == 12'h000) else $error("step with ticks");
   tick_step_a: assert property (
      $changed(subcycle_ticks) |-> subcycle_ticks == 12'h000
      || subcycle_ticks == $past(subcycle_ticks) + 12'h001) else $error("tick jump");
   done_pin_a: assert property (
      $past(presetn) |-> cycle_done_pin.drive == $past(iso_cycle_end)) else $error("done pin");
   fifo_pin_a: assert property (
      $past(presetn) |-> receive_fifo_empty_pin.drive == $past(fifo_empty)) else $error("fifo pin");
   mark_cause_a: assert property (
      cycle_mark_write |-> $past(iso_cycle_end)) else $error("mark without cycle end");
   hit_cause_a: assert property (
      iso_port_one_hit |-> $past(iso_header.valid)) else $error("hit without header");
   cover property (cycle_start_send);
   cover property (cycle_mark_write);
   cover property (iso_port_one_hit);
endmodule // link_regs_props

bind link_control_and_interrupt_regs link_regs_props link_regs_props_inst (.pclk, .presetn,
   .root_attached, .iso_cycle_end, .fifo_empty, .iso_header, .cycle_start_send,
   .cycle_mark_write, .iso_port_one_hit, .cycle_number, .subcycle_ticks,
   .receive_fifo_empty_pin, .cycle_done_pin, .cycle_start_pin);

// [dv/link_host_model.sv]
// Host bus model issuing register transfers to the bank
module link_host_model
(
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle bus at time zero
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end

   // Setup, access until ready, then release with inverted lines
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule // link_host_model

// [dv/link_control_and_interrupt_regs_bench.sv]
// Self-checking bench for the link control and interrupt bank
module link_control_and_interrupt_regs_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int          tpc  = 8;
   localparam int          cpf  = 4;
   localparam logic [7:0]  ctl  = link_regs_pkg::link_control_offset;
   localparam logic [7:0]  flg  = link_regs_pkg::interrupt_flags_offset;
   localparam logic [7:0]  ena  = link_regs_pkg::interrupt_enables_offset;
   localparam logic [31:0] zero = 32'h0000_0000;
   localparam logic [31:0] one  = 32'h0000_0001;
   logic                          pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic                          root_attached, external_cycle_input, iso_cycle_end;
   logic                          fifo_empty, cycle_start_send, cycle_mark_write, err;
   logic                          iso_port_one_hit, iso_port_two_hit, interrupt_request_pin;
   logic [7:0]                    paddr;
   logic [31:0]                   pwdata, prdata, rd;
   logic [31:1]                   interrupt_events;
   logic [12:0]                   cycle_number, c0;
   logic [11:0]                   subcycle_ticks, t0;
   link_regs_pkg::iso_header_type iso_header;
   link_regs_pkg::pin_drive_type  receive_fifo_empty_pin, cycle_done_pin, cycle_start_pin;
   int                            error_cnt, samples_checked, cyc;

   link_control_and_interrupt_regs #(.ticks_per_cycle(tpc), .cycles_per_frame(cpf))
      link_control_and_interrupt_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .root_attached, .external_cycle_input,
      .iso_cycle_end, .fifo_empty, .iso_header, .interrupt_events, .cycle_start_send,
      .cycle_mark_write, .iso_port_one_hit, .iso_port_two_hit, .cycle_number,
      .subcycle_ticks, .receive_fifo_empty_pin, .cycle_done_pin, .cycle_start_pin,
      .interrupt_request_pin);
   link_host_model link_host_model_inst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr);

   // Clock
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   function automatic logic [31:0] b(input logic x);
      return {31'h0000_0000, x};
   endfunction
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      link_host_model_inst.xfer(1'b1, a, d, rd, err);
   endtask
   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      link_host_model_inst.xfer(1'b0, a, zero, rd, err);
      chk(what, rd, exp);
   endtask
   task automatic pulse_ev(input logic [31:1] m);
      @(posedge pclk);
      interrupt_events <= m;
      @(posedge pclk);
      interrupt_events <= '0;
   endtask
   task automatic t_reset;
      rdc("flags", flg, 32'h0100_0000);
      rdc("mask", ena, zero);
      chk("pin enable", b(cycle_start_pin.enable), zero);
      chk("irq", b(interrupt_request_pin), zero);
   endtask
   task automatic t_mask;
      wr(ena, 32'hFFFF_FFFF);
      rdc("mask all", ena, 32'hFFFF_FFFF);
      link_host_model_inst.xfer(1'b0, 8'h04, zero, rd, err);
      chk("unmapped", b(err), one);
      wr(ena, 32'h0000_0005);
      rdc("mask", ena, 32'h0000_0005);
   endtask
   task automatic t_irq;
      wr(flg, 32'hFFFF_FFFE);
      rdc("clear", flg, zero);
      pulse_ev(31'h0000_0001);
      rdc("unmasked", flg, 32'h0000_0002);
      pulse_ev(31'h0000_0002);
      #1;
      chk("irq set", b(interrupt_request_pin), one);
      rdc("summary", flg, 32'h0000_0007);
      wr(flg, one);
      rdc("summary kept", flg, 32'h0000_0007);
      wr(flg, 32'h0000_0004);
      rdc("summary drop", flg, 32'h0000_0002);
      chk("irq clear", b(interrupt_request_pin), zero);
      wr(link_regs_pkg::diagnostics_offset, one);
      wr(flg, one);
      rdc("direct", flg, one);
      wr(flg, 32'h0000_0004);
      rdc("recompute", flg, 32'h0000_0005);
      wr(link_regs_pkg::diagnostics_offset, zero);
   endtask
   task automatic t_timer;
      wr(ctl, 32'h0050_0000);
      c0 = cycle_number;
      for (int i = 0; i < 30 && cycle_number === c0; i++)
      begin
         @(posedge pclk);
         #1;
      end
      chk("step", {19'h0_0000, cycle_number}, 32'((c0 + 1) % cpf));
      chk("wrap ticks", {20'h0_0000, subcycle_ticks}, zero);
      chk("start", b(cycle_start_send), one);
      @(posedge pclk);
      #1;
      chk("start end", b(cycle_start_send), zero);
      wr(ctl, 32'h0020_0000);
      #1;
      c0 = cycle_number;
      t0 = subcycle_ticks;
      repeat (5) @(posedge pclk);
      chk("hold", {20'h0_0000, subcycle_ticks}, {20'h0_0000, t0});
      external_cycle_input <= 1'b1;
      repeat (5) @(posedge pclk);
      external_cycle_input <= 1'b0;
      #1;
      chk("ext step", {19'h0_0000, cycle_number}, 32'((c0 + 1) % cpf));
      chk("ext ticks", {20'h0_0000, subcycle_ticks}, zero);
   endtask
   task automatic t_pins;
      wr(link_regs_pkg::iso_channels_offset, 32'h0000_0905);
      wr(ctl, 32'h8380_0000);
      rdc("control", ctl, 32'h8380_0000);
      chk("pins on", b(cycle_done_pin.enable), one);
      iso_cycle_end <= 1'b1;
      fifo_empty <= 1'b0;
      iso_header <= '{1'b1, 6'h05};
      @(posedge pclk);
      iso_cycle_end <= 1'b0;
      iso_header <= '{1'b1, 6'h09};
      #1;
      chk("mark", b(cycle_mark_write), one);
      chk("port one", {30'h0000_0000, iso_port_one_hit, iso_port_two_hit}, 32'h0000_0002);
      @(posedge pclk);
      iso_header <= '0;
      #1;
      chk("port two", {30'h0000_0000, iso_port_one_hit, iso_port_two_hit}, one);
      chk("fifo pin", b(receive_fifo_empty_pin.drive), zero);
      wr(ctl, zero);
      iso_cycle_end <= 1'b1;
      @(posedge pclk);
      iso_cycle_end <= 1'b0;
      #1;
      chk("no mark", b(cycle_mark_write), zero);
      chk("pins off", b(cycle_done_pin.enable), zero);
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Hang guard
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         error_cnt++;
         end_of_test;
      end
   end

   // Main sequence
   initial
   begin
      presetn = 1'b0;
      root_attached = 1'b1;
      external_cycle_input = 1'b0;
      iso_cycle_end = 1'b0;
      fifo_empty = 1'b1;
      iso_header = '0;
      interrupt_events = '0;
      error_cnt = 0;
      samples_checked = 0;
      cyc = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_mask;
      t_irq;
      t_timer;
      t_pins;
      end_of_test;
   end
endmodule // link_control_and_interrupt_regs_bench
